// [hw/cap_top.sv]
// Notes on behaviour
// RULE1: one 16-bit attribute word fetched per invoking character
// RULE2: word bits 0 to 10 drive attribute port lines 0 to 10
// RULE3: port gate register enables each line; disabled lines stay low
// RULE4: redefinition register turns off internal blink, underline, strike, sub, super
// RULE5: reverse and highlight only pass through the port
// RULE6: software never sets superscript and subscript together
// RULE7: software counts ignored characters in the hidden count
// RULE8: ignored characters suppressed unless show_ignored_chars is one
// RULE9: masked compare of code with match value decides a fetch
// RULE10: zero mask invokes every non-fill character and ignores the latch bit
// RULE11: mask and value 80 hex invoke codes with top bit set
// RULE12: flag register holds mask high byte and value low byte
// RULE13: hide_invoking_char hides invoker and moves its word to next character
// RULE14: latched word covers following non-invoking characters; unlatched only its own
// RULE15: latched state survives windows, background and frame ends
// RULE16: bit 1 underline, bit 4 superscript, bit 15 latch; null latched cancels
// RULE17: fill_attr_fetch fetches one word for the first fill character of a run
// RULE18: zero character pointer segment takes fill word from segment attribute pointer
// RULE19: short window pads; fill word follows last fetched word
// RULE20: short row pads to 96 or 132; fill word from next location
// RULE21: attribute pointer steps one word per fetch, reloads each segment
// RULE22: latched state is zero after reset
//
// The implementer's own choices: the APB interface to the registers and the address map.
`include "cap_params.svh"
`timescale 1ns/100ps
`default_nettype none
module cap_top
  import cap_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic char_valid,
  input wire logic [7:0] char_code,
  input wire logic char_fill,
  input wire logic fill_first,
  output logic char_ready,
  input wire logic seg_start,
  input wire logic [23:0] seg_attr_ptr,
  input wire logic row_start,
  input wire logic row_end,
  input wire logic win_start,
  input wire logic win_end,
  input wire logic [7:0] win_span,
  output logic attr_req,
  output logic [23:0] attr_addr,
  input wire logic attr_ack,
  input wire logic [15:0] attr_rdata,
  output logic out_valid,
  output logic [7:0] out_code,
  output logic out_display,
  output logic [4:0] out_proc_attr,
  output logic out_cursor,
  output logic [10:0] attr_out_line,
  output logic [7:0] pad_count
);

  logic [15:0] match_q;
  logic [15:0] gate_q;
  logic [4:0] redef_q;
  logic [3:0] mode_q;
  cap_word_t latch_q;
  cap_word_t pend_q;
  logic pend_v_q;
  cap_state_e state_q;
  logic [23:0] ptr_q;
  logic [7:0] hold_code_q;
  logic [7:0] row_cnt_q;
  logic [7:0] win_cnt_q;
  logic [31:0] rdata_d;
  logic map_hit;
  logic setup;
  logic wr_en;
  logic [7:0] mask_b;
  logic [7:0] val_b;
  logic mask_zero;
  logic invoke;
  logic take;
  logic apply_now;
  cap_word_t word_now;
  logic word_invoked;
  logic [7:0] row_width;

  // ---------------- APB slave ----------------
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite & pready;

  always_comb begin
    map_hit = 1'b1;
    rdata_d = 32'h0000_0000;
    unique case (paddr)
      `CAP_OFS_MATCH: rdata_d[15:0] = match_q;
      `CAP_OFS_GATE: rdata_d[15:0] = gate_q;
      `CAP_OFS_REDEF: rdata_d[4:0] = redef_q;
      `CAP_OFS_MODE: rdata_d[3:0] = mode_q;
      `CAP_OFS_LATCH: rdata_d[15:0] = latch_q;
      `CAP_OFS_PTR: rdata_d[23:0] = ptr_q;
      `CAP_OFS_PAD: rdata_d[7:0] = pad_count;
      default: map_hit = 1'b0;
    endcase
  end

  // one wait-free access: pready rises for the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~map_hit;
      prdata <= setup & ~pwrite ? rdata_d : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_q <= `CAP_RST_MATCH;
      gate_q <= `CAP_RST_GATE;
      redef_q <= `CAP_RST_REDEF;
      mode_q <= `CAP_RST_MODE;
    end else if (wr_en) begin
      unique case (paddr)
        `CAP_OFS_MATCH: match_q <= pwdata[15:0]; // RULE12
        `CAP_OFS_GATE: gate_q <= pwdata[15:0]; // RULE3
        `CAP_OFS_REDEF: redef_q <= pwdata[4:0]; // RULE4
        `CAP_OFS_MODE: mode_q <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // ---------------- invoke decision ----------------
  assign mask_b = match_q[`CAP_MASK_HI:`CAP_MASK_LO];
  assign val_b = match_q[`CAP_VAL_HI:`CAP_VAL_LO];
  assign mask_zero = (mask_b == 8'h00); // RULE10
  assign take = char_valid & char_ready;
  // fill characters never match; only the run head may fetch
  always_comb begin
    if (char_fill) begin
      invoke = fill_first & mode_q[`CAP_MODE_FILL]; // RULE17
    end else begin
      invoke = ((char_code ^ val_b) & mask_b) == 8'h00; // RULE9 RULE11 RULE12
    end
  end

  // ---------------- fetch sequencer ----------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= CAP_ST_IDLE;
      char_ready <= 1'b0;
      attr_req <= 1'b0;
      attr_addr <= 24'h00_0000;
      hold_code_q <= 8'h00;
    end else begin
      unique case (state_q)
        CAP_ST_IDLE: begin
          char_ready <= 1'b1;
          if (take && invoke) begin
            state_q <= CAP_ST_FETCH; // RULE1
            char_ready <= 1'b0;
            attr_req <= 1'b1;
            attr_addr <= seg_start ? seg_attr_ptr : ptr_q; // RULE18
            hold_code_q <= char_code;
          end
        end
        CAP_ST_FETCH: begin
          if (attr_ack) begin
            state_q <= CAP_ST_IDLE;
            attr_req <= 1'b0;
            char_ready <= 1'b1;
          end
        end
      endcase
    end
  end

  // pointer reloads per segment, steps one word per fetch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_q <= 24'h00_0000;
    end else if (take && invoke) begin
      ptr_q <= (seg_start ? seg_attr_ptr : ptr_q) + `CAP_PTR_STEP; // RULE21 RULE19 RULE20
    end else if (seg_start) begin
      ptr_q <= seg_attr_ptr; // RULE21
    end
  end

  // ---------------- attribute application ----------------
  assign word_invoked = (state_q == CAP_ST_FETCH) & attr_ack;
  assign apply_now = word_invoked | (take & ~invoke);
  // pending unlatched word from a hidden invoker wins over the latched set
  assign word_now = word_invoked ? attr_rdata : (pend_v_q ? pend_q : latch_q); // RULE14

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_q <= 16'h0000; // RULE22
      pend_q <= 16'h0000;
      pend_v_q <= 1'b0;
    end else if (word_invoked) begin
      // latch state is never cleared by frame or window edges
      if (attr_rdata[`CAP_BIT_LATCH] && !mask_zero) begin
        latch_q <= attr_rdata; // RULE14 RULE15 RULE16
        pend_v_q <= 1'b0;
      end else if (mode_q[`CAP_MODE_HIDE]) begin
        pend_q <= attr_rdata; // RULE13
        pend_v_q <= 1'b1;
      end else begin
        pend_v_q <= 1'b0;
      end
    end else if (take && !invoke) begin
      pend_v_q <= 1'b0; // RULE14
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid <= 1'b0;
      out_code <= 8'h00;
      out_display <= 1'b0;
      out_proc_attr <= 5'h00;
      out_cursor <= 1'b0;
      attr_out_line <= 11'h000;
    end else begin
      out_valid <= apply_now;
      if (apply_now) begin
        out_code <= word_invoked ? hold_code_q : char_code;
        // reverse and highlight go only to the port
        out_proc_attr <= word_now[`CAP_PROC_HI:0] & ~redef_q; // RULE4 RULE5 RULE16
        out_cursor <= word_now[`CAP_BIT_CURSOR];
        attr_out_line <= word_now[`CAP_PORT_HI:0] & gate_q[`CAP_PORT_HI:0]; // RULE2 RULE3
        out_display <= ~(word_invoked & mode_q[`CAP_MODE_HIDE])
          & ~(word_now[`CAP_BIT_IGNORE] & ~mode_q[`CAP_MODE_SHOW]); // RULE8 RULE13
      end
    end
  end

  // ---------------- padding counts ----------------
  assign row_width = mode_q[`CAP_MODE_WIDTH] ? `CAP_ROW_WIDE : `CAP_ROW_NARROW;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      row_cnt_q <= 8'h00;
      win_cnt_q <= 8'h00;
      pad_count <= 8'h00;
    end else begin
      if (row_start) begin
        row_cnt_q <= 8'h00;
      end else if (take) begin
        row_cnt_q <= row_cnt_q + 8'h01;
      end
      if (win_start) begin
        win_cnt_q <= 8'h00;
      end else if (take) begin
        win_cnt_q <= win_cnt_q + 8'h01;
      end
      // upstream inserts this many fill characters
      if (win_end) begin
        pad_count <= (win_cnt_q < win_span) ? win_span - win_cnt_q : 8'h00; // RULE19
      end else if (row_end) begin
        pad_count <= (row_cnt_q < row_width) ? row_width - row_cnt_q : 8'h00; // RULE20
      end
    end
  end

endmodule
`default_nettype wire

// [hw/cap_params.svh]
`ifndef CAP_PARAMS_SVH
`define CAP_PARAMS_SVH
// register byte offsets
`define CAP_OFS_MATCH 8'h00
`define CAP_OFS_GATE 8'h04
`define CAP_OFS_REDEF 8'h08
`define CAP_OFS_MODE 8'h0C
`define CAP_OFS_LATCH 8'h10
`define CAP_OFS_PTR 8'h14
`define CAP_OFS_PAD 8'h18
// reset values
`define CAP_RST_MATCH 16'h0000
`define CAP_RST_GATE 16'h07FF
`define CAP_RST_REDEF 5'h00
`define CAP_RST_MODE 4'h0
// flag register fields
`define CAP_MASK_HI 15
`define CAP_MASK_LO 8
`define CAP_VAL_HI 7
`define CAP_VAL_LO 0
// attribute word fields
`define CAP_PORT_HI 10
`define CAP_PROC_HI 4
`define CAP_BIT_CURSOR 11
`define CAP_BIT_IGNORE 12
`define CAP_BIT_LATCH 15
// mode register fields
`define CAP_MODE_SHOW 0
`define CAP_MODE_HIDE 1
`define CAP_MODE_FILL 2
`define CAP_MODE_WIDTH 3
// row widths and pointer step
`define CAP_ROW_NARROW 8'd96
`define CAP_ROW_WIDE 8'd132
`define CAP_PTR_STEP 24'h000002
`endif

// [hw/cap_pkg.sv]
package cap_pkg;
  typedef enum logic [1:0] {
    CAP_ST_IDLE = 2'b01,
    CAP_ST_FETCH = 2'b10
  } cap_state_e;
  typedef logic [15:0] cap_word_t;
endpackage

// [test/cap_top_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module cap_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic char_valid,
  input wire logic char_ready,
  input wire logic char_fill,
  input wire logic fill_first,
  input wire logic attr_req,
  input wire logic attr_ack,
  input wire logic [23:0] attr_addr,
  input wire logic out_valid
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ans; psel && !penable |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("no pready");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("stray pslverr");
  property p_rd0; !pready |-> prdata == 32'h0; endproperty
  a_rd0: assert property (p_rd0) else $error("prdata not zero");
  property p_busy; attr_req |-> !char_ready; endproperty
  a_busy: assert property (p_busy) else $error("ready in fetch");
  property p_hold; attr_req && !attr_ack |=> attr_req && $stable(attr_addr); endproperty
  a_hold: assert property (p_hold) else $error("request moved");
  property p_done; attr_req && attr_ack |=> out_valid && !attr_req && char_ready; endproperty
  a_done: assert property (p_done) else $error("no output after word");
  property p_take; char_valid && char_ready |=> out_valid || attr_req; endproperty
  a_take: assert property (p_take) else $error("char lost");
  property p_fill; char_valid && char_ready && char_fill && !fill_first |=> !attr_req; endproperty
  a_fill: assert property (p_fill) else $error("fetch in fill run");
  c_fetch: cover property (attr_req && attr_ack);
  c_fill: cover property (char_valid && char_ready && char_fill);
  c_err: cover property (pslverr);
endmodule
bind cap_top cap_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .prdata(prdata), .char_valid(char_valid),
  .char_ready(char_ready), .char_fill(char_fill), .fill_first(fill_first),
  .attr_req(attr_req), .attr_ack(attr_ack), .attr_addr(attr_addr), .out_valid(out_valid));
`default_nettype wire

// [test/cap_mem_model.sv]
`timescale 1ns/100ps
`default_nettype none
module cap_mem (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic attr_req,
  input wire logic [23:0] attr_addr,
  output logic attr_ack,
  output logic [15:0] attr_rdata
);
  logic [15:0] mem [16];
  logic [3:0] wait_q;
  int lag = 0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      attr_ack <= 1'b0;
      attr_rdata <= 16'h0000;
      wait_q <= 4'h0;
    end else if (attr_req && !attr_ack && wait_q >= lag) begin
      attr_ack <= 1'b1;
      attr_rdata <= mem[attr_addr[4:1]];
      wait_q <= 4'h0;
    end else begin
      // no ack this cycle (idle or waiting): data toggles so stale words never look valid
      attr_ack <= 1'b0;
      attr_rdata <= ~attr_rdata;
      wait_q <= attr_req ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule
`default_nettype wire

// [test/cap_top_test.sv]
`include "cap_params.svh"
`timescale 1ns/100ps
`default_nettype none
module cap_top_test;
  import cap_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic char_valid, char_fill, fill_first, char_ready, seg_start, attr_req, attr_ack, out_valid;
  logic [7:0] paddr, char_code;
  logic [31:0] pwdata, prdata, r;
  logic [23:0] seg_attr_ptr, attr_addr, la;
  logic [15:0] attr_rdata;
  logic [4:0] out_proc_attr;
  logic [10:0] attr_out_line;
  logic out_display, out_cursor, row_start, row_end, win_start, win_end;
  logic [7:0] out_code, pad_count, win_span;
  int failures = 0, comparisons = 0, cyc = 0;
  cap_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .char_valid(char_valid), .char_code(char_code), .char_fill(char_fill),
    .fill_first(fill_first), .char_ready(char_ready), .seg_start(seg_start),
    .seg_attr_ptr(seg_attr_ptr), .row_start(row_start), .row_end(row_end),
    .win_start(win_start), .win_end(win_end), .win_span(win_span), .attr_req(attr_req),
    .attr_addr(attr_addr), .attr_ack(attr_ack), .attr_rdata(attr_rdata),
    .out_valid(out_valid), .out_code(out_code), .out_display(out_display),
    .out_proc_attr(out_proc_attr), .out_cursor(out_cursor),
    .attr_out_line(attr_out_line), .pad_count(pad_count));
  cap_mem mem_u (.pclk(pclk), .presetn(presetn), .attr_req(attr_req),
    .attr_addr(attr_addr), .attr_ack(attr_ack), .attr_rdata(attr_rdata));
  task automatic conclude();
    if (failures == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic send(input logic [7:0] c, input logic f, input logic [4:0] ep,
    input logic [10:0] el);
    int n;
    n = 0;
    char_code <= c;
    char_fill <= f;
    fill_first <= f && c[0];
    char_valid <= 1'b1;
    do @(posedge pclk); while (char_ready !== 1'b1 && ++n < 50);
    char_valid <= 1'b0;
    for (n = 0; out_valid !== 1'b1 && n < 50; n++) begin
      if (attr_req) la = attr_addr;
      @(posedge pclk);
    end
    chk(out_code, c);
    if (el != 11'h7FF) begin
      chk(out_proc_attr, ep);
      chk(attr_out_line, el);
    end
    @(posedge pclk);
  endtask
  task automatic seg(input logic [23:0] p);
    seg_start <= 1'b1;
    seg_attr_ptr <= p;
    @(posedge pclk);
    seg_start <= 1'b0;
  endtask
  task automatic t_regs();
    apb(0, `CAP_OFS_MATCH, 0); chk(r, 32'h0000);
    apb(0, `CAP_OFS_GATE, 0); chk(r, 32'h07FF);
    apb(0, `CAP_OFS_LATCH, 0); chk(r, 32'h0000);
    apb(1, `CAP_OFS_GATE, 32'h607F);
    apb(0, `CAP_OFS_GATE, 0); chk(r, 32'h607F);
    apb(1, 8'h1C, 32'h1); chk(e, 1'b1);
  endtask
  task automatic t_latch();
    mem_u.mem[0] = 16'h8462;
    mem_u.mem[1] = 16'h8010;
    mem_u.mem[2] = 16'h8000;
    apb(1, `CAP_OFS_MATCH, 32'h8080);
    seg(24'h000100);
    send(8'h81, 0, 5'h02, 11'h062);
    send(8'h43, 0, 5'h02, 11'h062);
    send(8'h82, 0, 5'h10, 11'h010);
    send(8'h44, 0, 5'h10, 11'h010);
    send(8'h83, 0, 5'h00, 11'h000);
    chk(la, 24'h000104);
    send(8'h45, 0, 5'h00, 11'h000);
  endtask
  task automatic t_hide();
    mem_u.mem[0] = 16'h0002;
    mem_u.lag = 3;
    apb(1, `CAP_OFS_MATCH, 32'hFF10);
    apb(1, `CAP_OFS_MODE, 32'h2);
    seg(24'h000300);
    send(8'h10, 0, 5'h00, 11'h7FF);
    chk(out_display, 1'b0);
    send(8'h41, 0, 5'h02, 11'h002);
    chk(out_display, 1'b1);
    send(8'h11, 0, 5'h00, 11'h000);
    mem_u.lag = 0;
  endtask
  task automatic t_each();
    mem_u.mem[0] = 16'h8010;
    mem_u.mem[1] = 16'h0002;
    apb(1, `CAP_OFS_MODE, 32'h0);
    apb(1, `CAP_OFS_MATCH, 32'h0000);
    apb(1, `CAP_OFS_REDEF, 32'h02);
    seg(24'h000200);
    send(8'h05, 0, 5'h10, 11'h010);
    send(8'h06, 0, 5'h00, 11'h002);
    apb(1, `CAP_OFS_REDEF, 32'h0);
  endtask
  task automatic t_fill();
    mem_u.mem[0] = 16'h8002;
    // a nonzero mask keeps the latch bit of the fill word in force
    apb(1, `CAP_OFS_MATCH, 32'hFF10);
    apb(1, `CAP_OFS_MODE, 32'h4);
    seg(24'h000400);
    send(8'h21, 1, 5'h02, 11'h002);
    send(8'h20, 1, 5'h02, 11'h002);
  endtask
  task automatic t_show();
    mem_u.mem[0] = 16'h1800;
    mem_u.mem[1] = 16'h1000;
    apb(1, `CAP_OFS_MODE, 32'h0);
    seg(24'h000500);
    send(8'h10, 0, 5'h00, 11'h000);
    chk(out_display, 1'b0);
    chk(out_cursor, 1'b1);
    apb(1, `CAP_OFS_MODE, 32'h1);
    send(8'h10, 0, 5'h00, 11'h000);
    chk(out_display, 1'b1);
  endtask
  task automatic t_pad();
    apb(1, `CAP_OFS_MODE, 32'h0);
    row_start <= 1'b1;
    win_start <= 1'b1;
    win_span <= 8'h05;
    @(posedge pclk);
    row_start <= 1'b0;
    win_start <= 1'b0;
    send(8'h31, 0, 5'h02, 11'h002);
    send(8'h32, 0, 5'h02, 11'h002);
    win_end <= 1'b1;
    @(posedge pclk);
    win_end <= 1'b0;
    @(posedge pclk);
    chk(pad_count, 8'h03);
    row_end <= 1'b1;
    @(posedge pclk);
    row_end <= 1'b0;
    @(posedge pclk);
    chk(pad_count, 8'h5E);
    apb(1, `CAP_OFS_MODE, 32'h8);
    row_end <= 1'b1;
    @(posedge pclk);
    row_end <= 1'b0;
    @(posedge pclk);
    chk(pad_count, 8'h82);
  endtask
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      conclude();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, char_valid, char_fill, fill_first, seg_start} = '0;
    {paddr, char_code, pwdata, seg_attr_ptr} = '0;
    {row_start, row_end, win_start, win_end, win_span} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_regs();
    t_latch();
    t_hide();
    t_each();
    t_fill();
    t_show();
    t_pad();
    conclude();
  end
endmodule
`default_nettype wire
